// ---- cps_pkg.sv ----
// constants, register map and carrier types of the capacitive sensor status readout
// assumes a single 125 MHz system clock and a host reaching the map over the serial two-wire pins
package cps_pkg;

  // register map, byte addresses on the serial bus
  localparam logic [7:0] SYSTEM_FLAGS_ADDR = 8'h10;
  localparam logic [7:0] NEAR_DETECT_STATUS_ADDR = 8'h31;
  localparam logic [7:0] TOUCH_STATUS_ADDR = 8'h35;
  localparam logic [7:0] TOUCH_MODE_STATUS_ADDR = 8'h36;
  localparam logic [7:0] DYNAMIC_OUTPUT_STATUS_ADDR = 8'h37;
  localparam logic [7:0] BASELINE_FREEZE_STATUS_ADDR = 8'h39;
  localparam logic [7:0] CHANNEL_SELECT_VIEW_ADDR = 8'h3D;
  localparam logic [7:0] SAMPLE_COUNT_HIGH_ADDR = 8'h42;
  localparam logic [7:0] SAMPLE_COUNT_LOW_ADDR = 8'h43;
  localparam logic [7:0] BASELINE_HIGH_ADDR = 8'h83;
  localparam logic [7:0] BASELINE_LOW_ADDR = 8'h84;
  // third settings byte, only its reset-acknowledge bit is kept here
  localparam logic [7:0] SETTINGS2_ADDR = 8'hD3;
  localparam int RESET_ACK_BIT = 7;

  // system flags field positions
  localparam int RESET_SEEN_BIT = 5;
  localparam int SENSING_TECH_BIT = 4;
  localparam int LOW_RATE_BIT = 3;
  localparam int TUNE_BUSY_BIT = 2;
  localparam int NOISE_BIT = 1;
  localparam int ZOOM_BIT = 0;
  // combined boolean result position in the touch status byte
  localparam int COMBINED_BIT = 7;

  localparam logic RESET_SEEN_RST = 1'b1;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int NUM_CHANNELS = 3;
  localparam logic [15:0] HALT_MARGIN = 16'h0010;
  localparam logic [6:0] DEVICE_ADDR = 7'h44;

  // flags handed in by the sensing core, all on clk
  typedef struct packed {
    logic projected;
    logic low_power_en;
    logic low_rate_active;
    logic tune_busy;
    logic noise_seen;
    logic raw_prox;
    logic normal_power_mode;
  } cps_core_flags_t;

  typedef struct packed {
    logic [15:0] counts;
    logic [15:0] long_term_average;
  } cps_chan_meas_t;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_REG_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RACK
  } cps_bus_state_t;

endpackage

// ---- cps_pin_filter.sv ----
// three-stage sampler for pins arriving from outside the clk domain
// assumes pins change slowly against clk; a new level is taken once stages two and three agree
`timescale 1ns/1ns
module cps_pin_filter #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, level_r;
  logic [WIDTH-1:0] level_nxt;

  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        level_nxt[i] = s3_r[i];
      end
    end
  end

  // idle bus level is high, so every stage resets high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      level_r <= '1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;

endmodule

// ---- cps_chan_track.sv ----
// per-channel touch-mode, dynamic output and baseline freeze tracking
// assumes prox, touch and measurements come from the sensing core on clk
`timescale 1ns/1ns
module cps_chan_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic prox,
  input wire logic touch,
  input wire logic dyn_cal_en,
  input wire logic output_on_touch,
  input wire logic projected,
  input wire cps_pkg::cps_chan_meas_t meas,
  output logic touch_mode,
  output logic dyn_out,
  output logic halt
);

  logic tm_r, tm_nxt, out_r, out_nxt, halt_r, halt_nxt;
  logic [16:0] cs_ext, lta_ext;
  logic far_off;

  always_comb begin
    cs_ext = {1'b0, meas.counts};
    lta_ext = {1'b0, meas.long_term_average};
    // self counts rise on a target, projected counts fall
    if (projected) begin
      far_off = lta_ext > cs_ext + {1'b0, cps_pkg::HALT_MARGIN};
    end else begin
      far_off = cs_ext > lta_ext + {1'b0, cps_pkg::HALT_MARGIN};
    end
    tm_nxt = tm_r;
    if (!dyn_cal_en || !prox) begin
      tm_nxt = 1'b0;
    end else if (touch) begin
      tm_nxt = 1'b1;
    end
    if (tm_nxt && !tm_r) begin
      halt_nxt = 1'b0;
    end else if (tm_nxt) begin
      halt_nxt = far_off;
    end else begin
      halt_nxt = prox;
    end
    out_nxt = dyn_cal_en && (output_on_touch ? tm_nxt : prox);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_r <= 1'b0;
      out_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      tm_r <= tm_nxt;
      out_r <= out_nxt;
      halt_r <= halt_nxt;
    end
  end

  assign touch_mode = tm_r;
  assign dyn_out = out_r;
  assign halt = halt_r;

endmodule

// ---- cps_status_readout.sv ----
// status and measurement register bank of a three-channel capacitive sensor, read over a two-wire serial slave
// assumes the sensing core drives its results on clk; scl and sda are open-drain pins sampled by clk
//
// How it works
// - every status and measurement byte is reached through the serial slave by address.
// - reset-seen flag sets on reset, clears when host writes ack bit in settings byte three.
// - system flags bit 4 shows sensing technology, zero self, one projected.
// - low-rate flag is one while low power charging runs at reduced rate.
// - auto-tune flag is one while automatic tuning runs.
// - noise flag is one while interference has been detected.
// - zoom flag follows undebounced proximity and forces full speed unless normal power.
// - proximity byte holds one bit per channel, upper bits read zero.
// - touch byte holds one bit per channel, bits 6 to 3 read zero.
// - touch byte bit 7 equals the combined boolean output pin.
// - touch-mode bit sets when a dynamic channel exceeds touch threshold, clears when proximity or dynamic calibration drops.
// - dynamic output bit follows proximity, or touch mode when output-on-touch is set; it reads zero on a channel without dynamic calibration.
// - outside touch mode proximity sets halt and freezes the long-term average.
// - touch clears halt; it sets again only when counts stray more than 16 past average.
// - channel pointer byte names the channel, 0 to 2, whose data is readable.
// - sample counts read high byte first, low byte at next address.
// - long-term average reads high byte first, low byte at next address.
`timescale 1ns/1ns
module cps_status_readout #(
  parameter logic [6:0] SLAVE_ADDR = cps_pkg::DEVICE_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire cps_pkg::cps_core_flags_t core_flags,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] ch_prox,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] ch_touch,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] dyn_cal_en,
  input wire logic output_on_touch,
  input wire logic boolean_result,
  input wire logic [1:0] channel_pointer,
  input wire cps_pkg::cps_chan_meas_t [cps_pkg::NUM_CHANNELS-1:0] ch_meas,
  output logic combined_out,
  output logic full_speed_req,
  output logic [cps_pkg::NUM_CHANNELS-1:0] baseline_freeze
);

  localparam int NCH = cps_pkg::NUM_CHANNELS;

  // synchronised pins
  logic [1:0] pins_lvl;
  logic scl_f, sda_f, scl_q_r, sda_q_r;
  logic bus_start, bus_stop, scl_rise, scl_fall;

  cps_pin_filter #(
    .WIDTH(2)
  ) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .pin({scl_i, sda_i}),
    .level(pins_lvl)
  );

  assign scl_f = pins_lvl[1];
  assign sda_f = pins_lvl[0];
  // start and stop are data edges while the filtered clock stays high
  assign bus_start = scl_f && scl_q_r && sda_q_r && !sda_f;
  assign bus_stop = scl_f && scl_q_r && !sda_q_r && sda_f;
  assign scl_rise = scl_f && !scl_q_r;
  assign scl_fall = !scl_f && scl_q_r;

  // channel tracking
  logic [NCH-1:0] tm_w, dout_w, halt_w;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    cps_chan_track u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .prox(ch_prox[c]),
      .touch(ch_touch[c]),
      .dyn_cal_en(dyn_cal_en[c]),
      .output_on_touch(output_on_touch),
      .projected(core_flags.projected),
      .meas(ch_meas[c]),
      .touch_mode(tm_w[c]),
      .dyn_out(dout_w[c]),
      .halt(halt_w[c])
    );
  end

  // status snapshot, one clock behind the core
  logic reset_seen_r, reset_seen_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [NCH-1:0] prox_r, touch_r;
  logic combined_r, full_speed_r, full_speed_nxt;
  logic [1:0] chan_r;
  logic [15:0] counts_r, lta_r, counts_nxt, lta_nxt;
  logic ack_reset;

  always_comb begin
    reset_seen_nxt = reset_seen_r;
    if (ack_reset) begin
      reset_seen_nxt = 1'b0;
    end
    flags_nxt = 8'h00;
    flags_nxt[cps_pkg::RESET_SEEN_BIT] = reset_seen_r;
    flags_nxt[cps_pkg::SENSING_TECH_BIT] = core_flags.projected;
    // a zoomed channel charges at full speed, so it cannot be at the reduced rate
    flags_nxt[cps_pkg::LOW_RATE_BIT] = core_flags.low_power_en && core_flags.low_rate_active
      && !core_flags.raw_prox;
    flags_nxt[cps_pkg::TUNE_BUSY_BIT] = core_flags.tune_busy;
    flags_nxt[cps_pkg::NOISE_BIT] = core_flags.noise_seen;
    flags_nxt[cps_pkg::ZOOM_BIT] = core_flags.raw_prox;
    full_speed_nxt = core_flags.raw_prox && !core_flags.normal_power_mode;
    // a pointer past the last channel reads zero instead of an unknown word
    counts_nxt = 16'h0000;
    lta_nxt = 16'h0000;
    if (int'(channel_pointer) < NCH) begin
      counts_nxt = ch_meas[channel_pointer].counts;
      lta_nxt = ch_meas[channel_pointer].long_term_average;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_seen_r <= cps_pkg::RESET_SEEN_RST;
      flags_r <= 8'h00;
      prox_r <= '0;
      touch_r <= '0;
      combined_r <= 1'b0;
      full_speed_r <= 1'b0;
      chan_r <= 2'h0;
      counts_r <= 16'h0000;
      lta_r <= 16'h0000;
    end else begin
      reset_seen_r <= reset_seen_nxt;
      flags_r <= flags_nxt;
      prox_r <= ch_prox;
      touch_r <= ch_touch;
      combined_r <= boolean_result;
      full_speed_r <= full_speed_nxt;
      chan_r <= channel_pointer;
      counts_r <= counts_nxt;
      lta_r <= lta_nxt;
    end
  end

  assign combined_out = combined_r;
  assign full_speed_req = full_speed_r;
  assign baseline_freeze = halt_w;

  // byte read decode; unmapped and unused bits read zero
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] d;
    d = cps_pkg::UNMAPPED_READ;
    case (addr)
      cps_pkg::SYSTEM_FLAGS_ADDR: d = flags_r;
      cps_pkg::NEAR_DETECT_STATUS_ADDR: d = {5'h00, prox_r};
      cps_pkg::TOUCH_STATUS_ADDR: d = {combined_r, 4'h0, touch_r};
      cps_pkg::TOUCH_MODE_STATUS_ADDR: d = {5'h00, tm_w};
      cps_pkg::DYNAMIC_OUTPUT_STATUS_ADDR: d = {5'h00, dout_w};
      cps_pkg::BASELINE_FREEZE_STATUS_ADDR: d = {5'h00, halt_w};
      cps_pkg::CHANNEL_SELECT_VIEW_ADDR: d = {6'h00, chan_r};
      cps_pkg::SAMPLE_COUNT_HIGH_ADDR: d = counts_r[15:8];
      cps_pkg::SAMPLE_COUNT_LOW_ADDR: d = counts_r[7:0];
      cps_pkg::BASELINE_HIGH_ADDR: d = lta_r[15:8];
      cps_pkg::BASELINE_LOW_ADDR: d = lta_r[7:0];
      default: d = cps_pkg::UNMAPPED_READ;
    endcase
    return d;
  endfunction

  // serial slave
  cps_pkg::cps_bus_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic rw_r, rw_nxt, nack_r, nack_nxt, oe_n_r, oe_n_nxt, ack_nxt, ack_r;
  logic [7:0] rd_byte;

  assign rd_byte = read_byte(ptr_r);
  assign ack_reset = ack_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    oe_n_nxt = oe_n_r;
    ack_nxt = 1'b0;
    if (bus_start) begin
      st_nxt = cps_pkg::BUS_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end else if (bus_stop) begin
      st_nxt = cps_pkg::BUS_IDLE;
      oe_n_nxt = 1'b1;
    end else if (scl_rise) begin
      cnt_nxt = cnt_r + 4'h1;
      shift_nxt = {shift_r[6:0], sda_f};
      if (st_r == cps_pkg::BUS_RACK) begin
        nack_nxt = sda_f;
      end
    end else if (scl_fall) begin
      case (st_r)
        cps_pkg::BUS_ADDR: begin
          if (cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            if (shift_r[7:1] == SLAVE_ADDR) begin
              rw_nxt = shift_r[0];
              oe_n_nxt = 1'b0;
              st_nxt = cps_pkg::BUS_ADDR_ACK;
            end else begin
              st_nxt = cps_pkg::BUS_IDLE;
            end
          end
        end
        cps_pkg::BUS_ADDR_ACK, cps_pkg::BUS_RACK: begin
          cnt_nxt = 4'h0;
          if (st_r == cps_pkg::BUS_RACK && nack_r) begin
            oe_n_nxt = 1'b1;
            st_nxt = cps_pkg::BUS_IDLE;
          end else if (st_r == cps_pkg::BUS_RACK || rw_r) begin
            // pointer steps so a high/low pair reads in one burst
            oe_n_nxt = rd_byte[7];
            tx_nxt = {rd_byte[6:0], 1'b0};
            ptr_nxt = ptr_r + 8'h01;
            st_nxt = cps_pkg::BUS_RDATA;
          end else begin
            oe_n_nxt = 1'b1;
            st_nxt = cps_pkg::BUS_REG;
          end
        end
        cps_pkg::BUS_REG, cps_pkg::BUS_WDATA: begin
          if (cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b0;
            if (st_r == cps_pkg::BUS_REG) begin
              ptr_nxt = shift_r;
              st_nxt = cps_pkg::BUS_REG_ACK;
            end else begin
              // only the reset-acknowledge bit has an effect; other bytes drop the data
              ack_nxt = (ptr_r == cps_pkg::SETTINGS2_ADDR) && shift_r[cps_pkg::RESET_ACK_BIT];
              ptr_nxt = ptr_r + 8'h01;
              st_nxt = cps_pkg::BUS_WDATA_ACK;
            end
          end
        end
        cps_pkg::BUS_REG_ACK, cps_pkg::BUS_WDATA_ACK: begin
          cnt_nxt = 4'h0;
          oe_n_nxt = 1'b1;
          st_nxt = cps_pkg::BUS_WDATA;
        end
        cps_pkg::BUS_RDATA: begin
          if (cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
            st_nxt = cps_pkg::BUS_RACK;
          end else begin
            oe_n_nxt = tx_r[7];
            tx_nxt = {tx_r[6:0], 1'b0};
          end
        end
        default: begin
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= cps_pkg::BUS_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      oe_n_r <= 1'b1;
      ack_r <= 1'b0;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      oe_n_r <= oe_n_nxt;
      ack_r <= ack_nxt;
    end
  end

  // open drain: data is always low, the enable decides
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_r;

endmodule

// ---- cps_status_readout_monitor.sv ----
// checker for the sensor status readout: bus timing, combined output, full-speed request, baseline freeze
// assumes it is bound to cps_status_readout; one clk domain with async active-low reset
`timescale 1ns/1ns
module cps_status_readout_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input wire cps_pkg::cps_core_flags_t core_flags,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] ch_prox,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] ch_touch,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] dyn_cal_en,
  input wire logic boolean_result,
  input wire cps_pkg::cps_chan_meas_t [cps_pkg::NUM_CHANNELS-1:0] ch_meas,
  input wire logic combined_out,
  input wire logic full_speed_req,
  input wire logic [cps_pkg::NUM_CHANNELS-1:0] baseline_freeze
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // freeze checks wait four clk so that one or two register stages both pass
  wire tm0 = dyn_cal_en[0] && ch_prox[0] && ch_touch[0];
  wire proj = core_flags.projected;
  wire [15:0] cnt0 = ch_meas[0].counts;
  wire [15:0] lta0 = ch_meas[0].long_term_average;
  property p_comb;
    $stable(boolean_result) |=> combined_out == $past(boolean_result);
  endproperty
  a_comb: assert property (p_comb) else $error("combined output lags");
  property p_fast_set;
    core_flags.raw_prox && !core_flags.normal_power_mode |=> full_speed_req;
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("no full speed on proximity");
  property p_fast_np;
    core_flags.normal_power_mode |=> !full_speed_req;
  endproperty
  a_fast_np: assert property (p_fast_np) else $error("rate changed in normal power");
  property p_fast_clr;
    !core_flags.raw_prox |=> !full_speed_req;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("full speed without proximity");
  property p_freeze_prox;
    (ch_prox[2] && !dyn_cal_en[2]) [*4] |-> baseline_freeze[2];
  endproperty
  a_freeze_prox: assert property (p_freeze_prox) else $error("proximity did not freeze");
  property p_freeze_idle;
    !ch_prox[0] [*4] |-> !baseline_freeze[0];
  endproperty
  a_freeze_idle: assert property (p_freeze_idle) else $error("frozen without proximity");
  property p_touch_keep;
    (tm0 && !proj && cnt0 == lta0 + 16'h0010) [*4] |-> !baseline_freeze[0];
  endproperty
  a_touch_keep: assert property (p_touch_keep) else $error("touch mode froze at margin");
  property p_touch_halt;
    (tm0 && !proj && cnt0 == lta0 + 16'h0011) [*4] |-> baseline_freeze[0];
  endproperty
  a_touch_halt: assert property (p_touch_halt) else $error("self margin did not freeze");
  property p_touch_proj;
    (tm0 && proj && lta0 == cnt0 + 16'h0011) [*4] |-> baseline_freeze[0];
  endproperty
  a_touch_proj: assert property (p_touch_proj) else $error("projected margin no freeze");
  property p_sda_quiet;
    $changed(sda_oe_n) |-> !scl_i;
  endproperty
  a_sda_quiet: assert property (p_sda_quiet) else $error("data moved while clock high");
  property p_sda_hold;
    $rose(scl_i) && !sda_oe_n |=> !sda_oe_n [*8];
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("low bit not held");
  c_tm_freeze: cover property (tm0 ##1 baseline_freeze[0]);
  c_dev_low: cover property ($rose(scl_i) && !sda_oe_n);
  c_fast: cover property (full_speed_req);
endmodule

// ---- cps_host_model.sv ----
// host side of the two-wire status bus: a master clocking at 160 ns per bit
// assumes the bench resolves the open-drain wire with a pull-up; clock stands high between frames
`timescale 1ns/1ns
module cps_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull_n
);
  initial begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end
  // every change lands 1 ns after a clk edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_x(input logic b, output logic r);
    w(5);
    sda_pull_n = b;
    w(5);
    scl = 1'b1;
    w(10);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    w(5);
    sda_pull_n = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda_pull_n = 1'b0;
    w(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(5);
    sda_pull_n = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda_pull_n = 1'b1;
    w(10);
  endtask
  task automatic xb(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic ka);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ak, ka);
  endtask
  // each byte is reached by its map address
  task automatic rd(input logic [7:0] a, input bit two, output logic [15:0] v, output logic ok);
    logic [7:0] h, l, q;
    logic k0, k1, k2, x;
    start();
    xb({cps_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, k0);
    xb(a, 1'b1, q, k1);
    start();
    xb({cps_pkg::DEVICE_ADDR, 1'b1}, 1'b1, q, k2);
    xb(8'hFF, !two, h, x);
    if (two) xb(8'hFF, 1'b1, l, x);
    stop();
    v = two ? {h, l} : {8'h00, h};
    ok = !(k0 | k1 | k2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xb({cps_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, k0);
    xb(a, 1'b1, q, k1);
    xb(d, 1'b1, q, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
endmodule

// ---- test_cps_status_readout.sv ----
// self-checking bench for the sensor status readout, reached through the host model
// assumes the default slave address and a pull-up on the data wire
`timescale 1ns/1ns
module test_cps_status_readout;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_pull_n, sda_o, sda_oe_n, combined_out, full_speed_req;
  logic output_on_touch = 1'b0;
  logic boolean_result = 1'b0;
  logic [2:0] ch_prox = 3'h0, ch_touch = 3'h0, dyn_cal_en = 3'h0, baseline_freeze;
  logic [1:0] channel_pointer = 2'h0;
  cps_pkg::cps_core_flags_t core_flags = 7'h00;
  cps_pkg::cps_chan_meas_t [2:0] ch_meas = 96'h0;
  int errors = 0;
  int checked = 0;
  wire sda = sda_pull_n & (sda_oe_n | sda_o);
  always #4 clk = ~clk;
  cps_status_readout i_cps_status_readout (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .core_flags(core_flags), .ch_prox(ch_prox), .ch_touch(ch_touch), .dyn_cal_en(dyn_cal_en),
    .output_on_touch(output_on_touch), .boolean_result(boolean_result), .channel_pointer(channel_pointer),
    .ch_meas(ch_meas), .combined_out(combined_out), .full_speed_req(full_speed_req),
    .baseline_freeze(baseline_freeze));
  cps_host_model i_cps_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull_n(sda_pull_n));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic get(input logic [7:0] a, input bit two, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    i_cps_host_model.rd(a, two, v, ok);
    chk("read ack", {15'h0000, ok}, 16'h0001);
    chk($sformatf("byte %h", a), v, exp);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_cps_host_model.wr(a, d, ok);
    chk("write ack", {15'h0000, ok}, 16'h0001);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    core_flags = 7'h74;
    get(8'h10, 1'b0, 16'h003A);
    put(8'h10, 8'hFF);
    put(8'hD3, 8'h7F);
    get(8'h10, 1'b0, 16'h003A);
    put(8'hD3, 8'h80);
    core_flags = 7'h3A;
    get(8'h10, 1'b0, 16'h0005);
    chk("full speed", {15'h0000, full_speed_req}, 16'h0001);
    core_flags = 7'h03;
    get(8'h10, 1'b0, 16'h0001);
    chk("full speed normal power", {15'h0000, full_speed_req}, 16'h0000);
    $display("test system flags done");
    ch_prox = 3'h5;
    ch_touch = 3'h3;
    boolean_result = 1'b1;
    get(8'h31, 1'b0, 16'h0005);
    get(8'h35, 1'b0, 16'h0083);
    chk("combined out", {15'h0000, combined_out}, 16'h0001);
    get(8'h36, 1'b0, 16'h0000);
    get(8'h37, 1'b0, 16'h0000);
    get(8'h39, 1'b0, 16'h0005);
    chk("baseline freeze", {13'h0000, baseline_freeze}, 16'h0005);
    // calibrated channels: touch-mode, dynamic output and baseline freeze bytes are checked
    core_flags = 7'h00;
    ch_meas[0] = 32'h0100_0100;
    dyn_cal_en = 3'h7;
    ch_touch = 3'h1;
    get(8'h36, 1'b0, 16'h0001);
    get(8'h37, 1'b0, 16'h0005);
    get(8'h39, 1'b0, 16'h0004);
    output_on_touch = 1'b1;
    get(8'h37, 1'b0, 16'h0001);
    ch_meas[0].counts = 16'h0110;
    get(8'h39, 1'b0, 16'h0004);
    ch_meas[0].counts = 16'h0111;
    get(8'h39, 1'b0, 16'h0005);
    core_flags = 7'h40;
    ch_meas[0].counts = 16'h00F0;
    get(8'h39, 1'b0, 16'h0004);
    ch_meas[0].counts = 16'h00EF;
    get(8'h39, 1'b0, 16'h0005);
    chk("baseline freeze projected", {13'h0000, baseline_freeze}, 16'h0005);
    $display("test channel status done");
    for (logic [1:0] p = 2'h0; p < 2'h3; p++) begin
      channel_pointer = p;
      ch_meas[p] = {6'h00, p, 8'hA1, 6'h04, p, 8'hB2};
      get(8'h3D, 1'b0, {14'h0000, p});
      get(8'h42, 1'b1, {6'h00, p, 8'hA1});
      get(8'h83, 1'b1, {6'h04, p, 8'hB2});
    end
    $display("test measurements done");
    // a reset in mid-run must raise the reset-seen flag again
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    get(8'h10, 1'b0, 16'h0030);
    $display("test mid-run reset done");
    get(8'h20, 1'b0, 16'h0000);
    put(8'h84, 8'h00);
    get(8'h83, 1'b1, 16'h12B2);
    $display("test unmapped and read-only done");
    final_report();
  end
  initial begin
    #600000;
    errors++;
    final_report();
  end
endmodule
bind cps_status_readout cps_status_readout_monitor i_cps_status_readout_monitor (.clk(clk), .rst_n(rst_n),
  .scl_i(scl_i), .sda_oe_n(sda_oe_n), .core_flags(core_flags), .ch_prox(ch_prox), .ch_touch(ch_touch),
  .dyn_cal_en(dyn_cal_en), .boolean_result(boolean_result), .ch_meas(ch_meas), .combined_out(combined_out),
  .full_speed_req(full_speed_req), .baseline_freeze(baseline_freeze));
